/* src/clk_stop_ctl.sv */
// host controller for lpddr2 clock change, clock stop and nop issue
// ************
// ************
`timescale 1ns/1ps
module clk_stop_ctl
    import clk_stop_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            change_req,
    input  wire logic            stop_req,
    input  wire logic [3:0]      new_div,
    input  wire logic            refresh_ok,
    input  wire logic            banks_quiet,
    input  wire logic            timing_met,
    input  wire logic            resume_req,
    input  wire logic            illegal_seen,
    output logic                 busy,
    output logic                 change_done,
    output logic                 need_mrw,
    output logic                 need_init,
    output logic                 ck_t,
    output logic                 ck_c,
    output logic                 cke,
    output logic                 cs_n,
    output logic [CA_W-1:0]      ca
);
    // ************
    // state
    // ************
    typedef struct packed {
        ctl_state_e      st;
        logic [2:0]      cnt;
        logic [3:0]      div;
        logic [3:0]      tgt;
        logic            stop;
        logic            cke;
        logic            cke_prev;
        logic            cs_n;
        logic [CA_W-1:0] ca;
        logic            done;
        logic            mrw;
        logic            init;
    } ctl_s;
    ctl_s s_reg;
    ctl_s s_next;

    logic run_ck;
    logic rise;
    logic go_ok;

    // change allowed only with refresh, banks and timing settled
    assign go_ok = refresh_ok && banks_quiet && timing_met;

    ck_gen u_ck (
        .clk      (clk),
        .rstn     (rstn),
        .run      (run_ck),
        .half_div (s_reg.div),
        .ck_t     (ck_t),
        .ck_c     (ck_c),
        .rise     (rise)
    );

    // ************
    // next state
    // ************
    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        run_ck      = !(s_reg.st == ST_CHANGE && s_reg.stop);
        if (rise) begin
            s_next.cke_prev = s_reg.cke;
        end
        case (s_reg.st)
            ST_RUN: begin
                // idle bus carries nop: cs high
                s_next.cs_n = 1'b1;
                s_next.ca   = CA_IDLE;
                if (illegal_seen) begin
                    s_next.init = 1'b1;
                end else if ((change_req || stop_req) && go_ok && rise) begin
                    s_next.tgt  = new_div;
                    s_next.stop = stop_req;
                    s_next.cke  = 1'b0;
                    s_next.cnt  = CNT_ZERO;
                    s_next.st   = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // keep original clock for two rises after cke low
                if (rise) begin
                    s_next.cnt = s_reg.cnt + 3'h1;
                    if (s_reg.cnt + 3'h1 >= HOLD_LOW_C) begin
                        s_next.st = ST_CHANGE;
                    end
                end
            end
            ST_CHANGE: begin
                // cke low throughout: safe to alter clock
                if (!s_reg.stop) begin
                    s_next.div = s_reg.tgt;
                end
                if (resume_req || !s_reg.stop) begin
                    s_next.stop = 1'b0;
                    s_next.cnt  = CNT_ZERO;
                    s_next.st   = ST_STABLE;
                end
            end
            ST_STABLE: begin
                if (rise) begin
                    s_next.cnt = s_reg.cnt + 3'h1;
                    if (s_reg.cnt + 3'h1 >= STABLE_C) begin
                        s_next.st = ST_EXIT;
                    end
                end
            end
            ST_EXIT: begin
                if (rise) begin
                    s_next.cke  = 1'b1;
                    s_next.cs_n = 1'b1;
                    s_next.st   = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                // nop only once cke level matched the prior cycle
                if (rise && s_reg.cke_prev == s_reg.cke) begin
                    s_next.cs_n = 1'b1;
                    s_next.done = 1'b1;
                    s_next.mrw  = 1'b1;
                    s_next.st   = ST_RUN;
                end
            end
            default: begin
                s_next.st = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_reg          <= '0;
            s_reg.st       <= ST_RUN;
            s_reg.div      <= DIV_FAST;
            s_reg.tgt      <= DIV_FAST;
            s_reg.cke      <= 1'b1;
            s_reg.cke_prev <= 1'b1;
            s_reg.cs_n     <= 1'b1;
            s_reg.ca       <= CA_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy        = (s_reg.st != ST_RUN);
    assign change_done = s_reg.done;
    assign need_mrw    = s_reg.mrw;
    assign need_init   = s_reg.init;
    assign cke         = s_reg.cke;
    assign cs_n        = s_reg.cs_n;
    assign ca          = s_reg.ca;

    // ************
    // checks
    // ************
    sequence cke_drop;
        $fell(cke);
    endsequence

    a_div_cke_low : assert property (@(posedge clk) disable iff (!rstn)
        $changed(s_reg.div) |-> !cke)
        else $error("divider changed with cke high");
    a_hold_two : assert property (@(posedge clk) disable iff (!rstn)
        cke_drop |-> s_reg.st == ST_HOLD)
        else $error("cke fell outside hold");
    a_start_ok : assert property (@(posedge clk) disable iff (!rstn)
        cke_drop |-> $past(go_ok))
        else $error("change started while not ready");
    a_cs_exit : assert property (@(posedge clk) disable iff (!rstn)
        $rose(cke) |-> cs_n)
        else $error("cs low at cke rise");
    a_nop_code : assert property (@(posedge clk) disable iff (!rstn)
        cs_n || ca[2:0] == NOP_CA_LOW)
        else $error("bus not carrying nop");
    a_stable_exit : assert property (@(posedge clk) disable iff (!rstn)
        $rose(cke) |-> $past(s_reg.st) == ST_EXIT)
        else $error("cke rose without stable clocks");
    a_done_level : assert property (@(posedge clk) disable iff (!rstn)
        change_done |-> cke && $past(cke))
        else $error("done with unstable cke");
    a_stop_park : assert property (@(posedge clk) disable iff (!rstn)
        (s_reg.st == ST_CHANGE && s_reg.stop) |=> (!ck_t && ck_c))
        else $error("stopped clock not parked");
endmodule

/* common/clk_stop_pkg.sv */
// constants for the lpddr2 clock stop and nop controller
package clk_stop_pkg;
    localparam int          CA_W          = 10;
    localparam int          CLK_MHZ       = 25;
    // cycles of original clock held after cke falls
    localparam int          HOLD_LOW_CYC  = 2;
    // stable clock cycles before cke rises again
    localparam int          STABLE_CYC    = 2;
    // reset clock divider for the fast link clock: half period is this value plus one clk cycles
    localparam logic [3:0]  DIV_FAST      = 4'h1;
    localparam logic [3:0]  CNT_W1        = 4'h1;
    localparam logic [2:0]  CNT_ZERO      = 3'h0;
    localparam logic [2:0]  HOLD_LOW_C    = 3'h2;
    localparam logic [2:0]  STABLE_C      = 3'h2;
    // nop encoding when chip select is low: ca0..ca2 high
    localparam logic [2:0]  NOP_CA_LOW    = 3'h7;
    localparam logic [9:0]  CA_IDLE       = 10'h007;
    typedef enum {
        ST_RUN,
        ST_CKE_FALL,
        ST_HOLD,
        ST_CHANGE,
        ST_STABLE,
        ST_EXIT,
        ST_RECOVER
    } ctl_state_e;
endpackage

/* src/ck_gen.sv */
// clock pattern generator with stop and selectable division
`timescale 1ns/1ps
module ck_gen
    import clk_stop_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic [3:0] half_div,
    output logic            ck_t,
    output logic            ck_c,
    output logic            rise
);
    // ************
    // state
    // ************
    typedef struct packed {
        logic [3:0] cnt;
        logic       ck;
    } gen_s;
    gen_s st_reg;
    gen_s st_next;

    always_comb begin
        st_next = st_reg;
        rise    = 1'b0;
        if (!run) begin
            // parked: true low, complement high
            st_next.ck  = 1'b0;
            st_next.cnt = 4'h0;
        end else if (st_reg.cnt >= half_div) begin
            st_next.cnt = 4'h0;
            st_next.ck  = ~st_reg.ck;
            rise        = ~st_reg.ck;
        end else begin
            st_next.cnt = st_reg.cnt + CNT_W1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ck_t = st_reg.ck;
    assign ck_c = ~st_reg.ck;

    a_park_levels : assert property (@(posedge clk) disable iff (!rstn)
        !run |=> (!ck_t && ck_c))
        else $error("clock not parked low");
endmodule

/* bench/dev_model.sv */
// behavioural lpddr2 device: decodes commands on ck rise
`timescale 1ns/1ps
module dev_model
    import clk_stop_pkg::*;
(
    input  wire logic            ck_t,
    input  wire logic            ck_c,
    input  wire logic            cke,
    input  wire logic            cs_n,
    input  wire logic [CA_W-1:0] ca,
    output logic [7:0]           nop_cnt,
    output logic [7:0]           cmd_cnt,
    output logic [7:0]           mode_reg
);
    logic            cke_prev;
    logic            cke_s;
    logic            cs_n_s;
    logic            ck_c_s;
    logic [CA_W-1:0] ca_s;
    initial begin
        nop_cnt  = 8'h00;
        cmd_cnt  = 8'h00;
        mode_reg = 8'hA5;
        cke_prev = 1'b1;
        cke_s    = 1'b1;
        cs_n_s   = 1'b1;
        ck_c_s   = 1'b1;
        ca_s     = CA_IDLE;
    end
    // pins launch on the ck rise itself: a rise registers the level
    // that stood through the low phase before it
    always @(negedge ck_t) begin
        #1;
        cke_s  = cke;
        cs_n_s = cs_n;
        ck_c_s = ck_c;
        ca_s   = ca;
    end
    // nop leaves mode register and bank state alone
    always @(posedge ck_t) begin
        if (ck_c_s && (cs_n_s || ca_s[2:0] == NOP_CA_LOW)) begin
            if (cke_s == cke_prev) begin
                nop_cnt <= nop_cnt + 8'h01;
            end
        end else begin
            cmd_cnt  <= cmd_cnt + 8'h01;
            // a stray command may disturb the mode state
            mode_reg <= mode_reg ^ 8'hFF;
        end
        cke_prev <= cke_s;
    end
endmodule

/* bench/tb_top.sv */
// testbench for the clock stop and nop controller
`timescale 1ns/1ps
module tb_top;
    import clk_stop_pkg::*;
    logic            clk, rstn, change_req, stop_req, resume_req;
    logic            illegal_seen, busy, change_done, need_mrw;
    logic            need_init, ck_t, ck_c, cke, cs_n;
    logic [2:0]      rdy;
    logic [3:0]      new_div;
    logic [CA_W-1:0] ca;
    logic [7:0]      nop_cnt, cmd_cnt, mode_reg, n0;
    int              miscompares, checks, p;
    // selectors of the outputs that await watches
    localparam int   W_CK   = 0;
    localparam int   W_CKE  = 1;
    localparam int   W_DONE = 2;

    clk_stop_ctl dut (.clk(clk), .rstn(rstn), .change_req(change_req),
        .stop_req(stop_req), .new_div(new_div), .refresh_ok(rdy[0]),
        .banks_quiet(rdy[1]), .timing_met(rdy[2]),
        .resume_req(resume_req), .illegal_seen(illegal_seen),
        .busy(busy), .change_done(change_done), .need_mrw(need_mrw),
        .need_init(need_init), .ck_t(ck_t), .ck_c(ck_c), .cke(cke),
        .cs_n(cs_n), .ca(ca));
    dev_model mem (.ck_t(ck_t), .ck_c(ck_c), .cke(cke), .cs_n(cs_n),
        .ca(ca), .nop_cnt(nop_cnt), .cmd_cnt(cmd_cnt),
        .mode_reg(mode_reg));

    always #20 clk = ~clk;

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    function automatic logic pick(int w);
        case (w)
            W_CK: return ck_t;
            W_CKE: return cke;
            default: return change_done;
        endcase
    endfunction
    task automatic await(int w, logic v, string nm);
        int k;
        k = 0;
        while (pick(w) !== v && k < 200) begin
            cyc(1);
            k++;
        end
        chk(nm, pick(w), v);
    endtask
    // clk cycles from one ck rise to the next
    task automatic period();
        await(W_CK, 1'b0, "ck_low");
        await(W_CK, 1'b1, "ck_high");
        p = 0;
        while (ck_t === 1'b1 && p < 99) begin
            cyc(1);
            p++;
        end
        while (ck_t === 1'b0 && p < 99) begin
            cyc(1);
            p++;
        end
    endtask
    task automatic t_refuse();
        change_req = 1'b1;
        for (int i = 0; i < 3; i++) begin
            rdy = 3'h7 ^ (3'h1 << i);
            cyc(16);
            chk("cke", cke, 1'b1);
            chk("busy", busy, 1'b0);
        end
        change_req = 1'b0;
        rdy = 3'h7;
        $display("test refuse done");
    endtask
    task automatic t_change();
        new_div = 4'h3;
        change_req = 1'b1;
        await(W_CKE, 1'b0, "cke_fall");
        change_req = 1'b0;
        period();
        chk("old_period", p, 16'h4);
        await(W_CKE, 1'b1, "cke_rise");
        chk("cs_n", cs_n, 1'b1);
        await(W_DONE, 1'b1, "done");
        chk("need_mrw", need_mrw, 1'b1);
        chk("busy", busy, 1'b0);
        cyc(1);
        chk("done_pulse", change_done, 1'b0);
        period();
        chk("new_period", p, 16'h8);
        chk("cmds", cmd_cnt, 8'h00);
        chk("nops", nop_cnt != 8'h00, 1'b1);
        $display("test change done");
    endtask
    task automatic t_stop();
        stop_req = 1'b1;
        await(W_CKE, 1'b0, "cke_fall");
        stop_req = 1'b0;
        cyc(60);
        n0 = nop_cnt;
        chk("ck_t", ck_t, 1'b0);
        chk("ck_c", ck_c, 1'b1);
        chk("busy", busy, 1'b1);
        cyc(20);
        chk("parked", nop_cnt, n0);
        resume_req = 1'b1;
        await(W_DONE, 1'b1, "done");
        resume_req = 1'b0;
        chk("cke", cke, 1'b1);
        chk("mode", mode_reg, 8'hA5);
        $display("test stop done");
    endtask
    task automatic t_illegal();
        chk("need_init", need_init, 1'b0);
        illegal_seen = 1'b1;
        cyc(2);
        illegal_seen = 1'b0;
        cyc(2);
        chk("need_init", need_init, 1'b1);
        $display("test illegal done");
    endtask
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        {change_req, stop_req, resume_req, illegal_seen} = 4'h0;
        rdy = 3'h7;
        new_div = 4'h1;
        cyc(10);
        chk("rst_ca", ca, CA_IDLE);
        chk("rst_pins", {cke, cs_n, ck_t, ck_c}, 4'hD);
        chk("rst_flags", {busy, need_mrw, need_init}, 3'h0);
        rstn = 1'b1;
        cyc(2);
        t_refuse();
        t_change();
        t_stop();
        t_illegal();
        end_sim();
    end
endmodule
